// ===== dv/cab_alu_branch_assertions.sv
/*
 * Checker for the ALU and branch unit: cycle counts, flag masks and PC
 * moves seen at the top module's ports.
 * Assumes it is bound to cab_alu_branch and that ce stays high.
 */
`default_nettype none
module cab_alu_branch_assertions (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	input wire cab_pkg::cab_bus_req_t bus_req,
	input wire logic [7:0] bus_rdata,
	input wire cab_pkg::cab_cmd_t cmd,
	input wire logic busy,
	input wire logic done,
	input wire logic [15:0] pc,
	input wire logic [7:0] status_flag_register
);
	timeunit 1ns;
	timeprecision 1ns;
	import cab_pkg::*;
	default clocking dc @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	logic take;
	logic flag_true;
	logic [7:0] sr;
	logic [15:0] rel;
	logic [15:0] pc1;
	logic [15:0] pc3;
	assign take = ce & cmd.valid & ~busy;
	assign sr = status_flag_register;
	assign flag_true = (cmd.sel == FLAG_S) ? sr[FLAG_N] ^ sr[FLAG_V]
		: sr[cmd.sel];
	assign rel = pc + {{4{cmd.k[11]}}, cmd.k} + 16'h0001;
	assign pc1 = pc + 16'h0001;
	assign pc3 = pc + 16'h0003;
	a_alu_one_cycle: assert property (
		take && cmd.op inside {OP_ADD, OP_ADD_CARRY, OP_SUB, OP_SUB_IMM,
		OP_SUB_CARRY, OP_TEST, OP_COMPARE, OP_COMPARE_IMM}
		|=> done && !busy && pc == $past(pc1))
		else $error("one-cycle op did not finish in one cycle");
	a_logic_flags: assert property (
		take && cmd.op inside {OP_AND, OP_AND_IMM, OP_OR, OP_OR_IMM,
		OP_XOR, OP_SET_BITS, OP_CLEAR_BITS, OP_TEST}
		|=> !sr[FLAG_V] && ((sr ^ $past(sr)) & 8'hF1) == 8'h00)
		else $error("logic op touched a flag outside Z, N and V");
	a_mul_two_cycle: assert property (
		take && cmd.op inside {OP_MULT_UU, OP_MULT_SS, OP_MULT_SU,
		OP_FRAC_MULT_UU, OP_FRAC_MULT_SS, OP_FRAC_MULT_SU}
		|=> busy && !done ##1 done && !busy)
		else $error("multiply did not take two cycles");
	a_word_sign_flag: assert property (
		take && cmd.op inside {OP_WORD_ADD_IMM, OP_WORD_SUB_IMM}
		|=> busy ##1 done && sr[FLAG_S] == (sr[FLAG_N] ^ sr[FLAG_V]))
		else $error("word op timing or sign flag wrong");
	a_ind_call_three: assert property (
		take && cmd.op == OP_IND_CALL |=> busy [*2] ##1 done)
		else $error("indirect call did not take three cycles");
	a_return_four: assert property (
		take && cmd.op inside {OP_DIR_CALL, OP_RETURN, OP_INT_RETURN}
		|=> busy [*3] ##1 done)
		else $error("call or return did not take four cycles");
	a_int_return_i: assert property (
		take && cmd.op == OP_INT_RETURN |=> sr[FLAG_I])
		else $error("interrupt return left the interrupt flag clear");
	a_rel_jump_pc: assert property (
		take && cmd.op == OP_REL_JUMP |=> pc == $past(rel) ##1 done)
		else $error("relative jump target or timing wrong");
	a_branch_taken: assert property (
		take && cmd.op == OP_BRANCH_FLAG_SET && flag_true
		|=> pc == $past(rel) && busy ##1 done)
		else $error("taken branch target or timing wrong");
	a_branch_not_taken: assert property (
		take && cmd.op == OP_BRANCH_FLAG_CLEAR && flag_true
		|=> done && !busy && pc == $past(pc1))
		else $error("untaken branch did not fall through in one cycle");
	a_skip_two_word: assert property (
		take && cmd.op == OP_SKIP_IO_BIT_SET && cmd.io_bit
		&& cmd.next_two_word |=> pc == $past(pc3) && busy ##1 busy ##1 done)
		else $error("skip over two-word op wrong");
	c_mult_signed: cover property (take && cmd.op == OP_MULT_SS);
	c_branch_set: cover property (take && cmd.op == OP_BRANCH_FLAG_SET);
	c_int_return: cover property (take && cmd.op == OP_INT_RETURN);
endmodule
bind cab_alu_branch cab_alu_branch_assertions chk_u (.clk_sys(clk_sys),
	.rst(rst), .ce(ce), .bus_req(bus_req), .bus_rdata(bus_rdata),
	.cmd(cmd), .busy(busy), .done(done), .pc(pc),
	.status_flag_register(status_flag_register));
`default_nettype wire

// ===== dv/tb_top.sv
/*
 * Self-checking bench for the ALU and branch unit: register port tasks
 * note expected read data in a queue that a monitor compares.
 * Assumes the port map, flag positions and op codes of cab_pkg.
 */
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import cab_pkg::*;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	cab_bus_req_t bus_req = '0;
	cab_cmd_t cmd = '0;
	cab_cmd_t c;
	logic [7:0] bus_rdata, sr, a, b, s, x, me;
	logic [15:0] pc, p, w;
	logic busy, done, t2, rd_seen = 1'b0;
	int failures = 0;
	int comparisons = 0;
	int seed = 32'haaeb;
	logic [7:0] exp_q[$];
	string name_q[$], mn;
	cab_op_t alu_ops[17] = '{OP_ADD, OP_ADD_CARRY, OP_SUB, OP_SUB_CARRY,
		OP_AND, OP_OR, OP_XOR, OP_COMPARE, OP_COMPARE_CARRY, OP_TEST,
		OP_SUB_IMM, OP_SUB_CARRY_IMM, OP_AND_IMM, OP_OR_IMM, OP_SET_BITS,
		OP_CLEAR_BITS, OP_COMPARE_IMM};
	cab_op_t mul_ops[6] = '{OP_MULT_UU, OP_MULT_SS, OP_MULT_SU,
		OP_FRAC_MULT_UU, OP_FRAC_MULT_SS, OP_FRAC_MULT_SU};
	cab_op_t sk_ops[5] = '{OP_COMPARE_SKIP_EQUAL, OP_SKIP_REG_BIT_CLEAR,
		OP_SKIP_REG_BIT_SET, OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET};
	cab_op_t ex_ops[5] = '{OP_INVERT, OP_NEGATE, OP_INCREMENT, OP_DECREMENT,
		OP_SET_ALL};
	always #20 clk_sys = ~clk_sys;
	cab_alu_branch dut_u (.clk_sys(clk_sys), .rst(rst), .ce(ce),
		.bus_req(bus_req), .bus_rdata(bus_rdata), .cmd(cmd), .busy(busy),
		.done(done), .pc(pc), .status_flag_register(sr));
	always @(posedge clk_sys) begin
		if (rd_seen) begin
			me = exp_q.pop_front();
			mn = name_q.pop_front();
			comparisons++;
			if (bus_rdata !== me) begin
				failures++;
				$display("ERROR %s expected %h seen %h", mn, me, bus_rdata);
			end
		end
		rd_seen <= bus_req.rd;
	end
	function automatic logic [7:0] r8();
		return 8'($random(seed));
	endfunction
	function automatic logic [15:0] alu(input cab_op_t op,
		input logic [7:0] a, input logic [7:0] b, input logic [7:0] s);
		logic [8:0] t;
		logic [7:0] r, p, q, bb;
		logic sub, cf, lg;
		sub = !(op inside {OP_ADD, OP_ADD_CARRY});
		cf = op inside {OP_ADD_CARRY, OP_SUB_CARRY, OP_SUB_CARRY_IMM,
			OP_COMPARE_CARRY};
		t = {1'b0, a} + b + (cf & s[FLAG_C]);
		if (sub)
			t = {1'b0, a} - b - (cf & s[FLAG_C]);
		r = t[7:0];
		p = sub ? ~a : a;
		q = sub ? r : ~r;
		bb = sub ? ~b : b;
		lg = 1'b1;
		case (op)
		OP_AND, OP_AND_IMM, OP_TEST: r = a & b;
		OP_OR, OP_OR_IMM, OP_SET_BITS: r = a | b;
		OP_XOR: r = a ^ b;
		OP_CLEAR_BITS: r = a & (8'hFF - b);
		default: begin
			lg = 1'b0;
			s[FLAG_C] = t[8];
			s[FLAG_H] = (p[3] & b[3]) | (b[3] & q[3]) | (q[3] & p[3]);
			s[FLAG_V] = (a[7] & bb[7] & ~r[7]) | (~a[7] & ~bb[7] & r[7]);
		end
		endcase
		if (lg)
			s[FLAG_V] = 1'b0;
		s[FLAG_N] = r[7];
		s[FLAG_Z] = (r == 8'h00) & (!(cf & sub) | s[FLAG_Z]);
		if (op inside {OP_COMPARE, OP_COMPARE_CARRY, OP_COMPARE_IMM})
			r = a;
		return {r, s};
	endfunction
	task automatic end_of_test();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic wr(input logic [7:0] ad, input logic [7:0] d);
		@(posedge clk_sys);
		bus_req <= '{1'b1, 1'b0, ad, d};
		@(posedge clk_sys);
		bus_req <= '0;
	endtask
	task automatic rd(input logic [7:0] ad, input logic [7:0] e,
		input string n);
		exp_q.push_back(e);
		name_q.push_back(n);
		@(posedge clk_sys);
		bus_req <= '{1'b0, 1'b1, ad, 8'h00};
		@(posedge clk_sys);
		bus_req <= '0;
	endtask
	task automatic chk_pc(input logic [15:0] v);
		rd(ADDR_PC_LO, v[7:0], "pc_lo");
		rd(ADDR_PC_HI, v[15:8], "pc_hi");
	endtask
	task automatic set_pc(input logic [15:0] v);
		wr(ADDR_PC_LO, v[7:0]);
		wr(ADDR_PC_HI, v[15:8]);
	endtask
	task automatic run(input cab_op_t op);
		int i;
		c.valid = 1'b1;
		c.op = op;
		@(posedge clk_sys);
		cmd <= c;
		@(posedge clk_sys);
		cmd <= '0;
		for (i = 0; i < 8; i++) begin
			#1;
			if (done === 1'b1)
				break;
			@(posedge clk_sys);
		end
		if (i == 8) begin
			failures++;
			$display("ERROR done expected 1 seen 0");
			end_of_test();
		end
	endtask
	initial begin
		repeat (6) @(posedge clk_sys);
		rst <= 1'b0;
		rd(ADDR_STATUS, STATUS_RESET, "status_reset");
		chk_pc(PC_RESET);
		rd(8'h05, REG_RESET, "reg_reset");
		wr(8'h30, 8'hA5);
		wr(ADDR_STACK_PTR, 8'h07);
		rd(8'h30, 8'h00, "unmapped");
		rd(ADDR_STACK_PTR, 8'h00, "stack_ptr");
		ce <= 1'b0;
		wr(8'h12, 8'h5A);
		ce <= 1'b1;
		rd(8'h12, REG_RESET, "ce_frozen");
		$display("reset test done");
		repeat (2) foreach (alu_ops[i]) begin
			a = r8();
			b = r8();
			s = r8();
			x = ~b;
			c = '0;
			c.rd = 5'h10;
			c.rr = 5'h11;
			c.imm = x;
			wr(8'h10, a);
			wr(8'h11, b);
			wr(ADDR_STATUS, s);
			run(alu_ops[i]);
			w = alu(alu_ops[i], a, i > 9 ? x : (i == 9 ? a : b), s);
			rd(8'h10, w[15:8], "alu_result");
			rd(ADDR_STATUS, w[7:0], "alu_flags");
		end
		$display("alu test done");
		foreach (ex_ops[i]) begin
			a = r8();
			s = r8();
			c = '0;
			c.rd = 5'h10;
			wr(8'h10, a);
			wr(ADDR_STATUS, s);
			run(ex_ops[i]);
			case (i)
			0: w = alu(OP_XOR, a, 8'hFF, s);
			1: w = alu(OP_SUB, 8'h00, a, s);
			2: w = alu(OP_OR, a + 8'h01, 8'h00, s);
			3: w = alu(OP_OR, a - 8'h01, 8'h00, s);
			default: w = {8'hFF, s};
			endcase
			if (i == 0)
				w[FLAG_C] = 1'b1;
			if (i inside {2, 3})
				w[FLAG_V] = (w[15:8] == (i == 2 ? 8'h80 : 8'h7F));
			rd(8'h10, w[15:8], "unary_result");
			rd(ADDR_STATUS, w[7:0], "unary_flags");
		end
		$display("unary test done");
		foreach (mul_ops[i]) begin
			a = r8();
			b = r8();
			s = r8();
			c = '0;
			c.rd = 5'h10;
			c.rr = 5'h11;
			wr(8'h10, a);
			wr(8'h11, b);
			wr(ADDR_STATUS, s);
			run(mul_ops[i]);
			p = {{8{a[7] & (i % 3 != 0)}}, a} * {{8{b[7] & (i % 3 == 1)}}, b};
			s[FLAG_C] = p[15];
			if (i > 2)
				p = p << 1;
			s[FLAG_Z] = (p == 16'h0000);
			rd(8'h00, p[7:0], "product_lo");
			rd(8'h01, p[15:8], "product_hi");
			rd(ADDR_STATUS, s, "mul_flags");
		end
		$display("multiply test done");
		for (int j = 0; j < 4; j++) begin
			w = j > 1 ? (j == 2 ? 16'h7FFF : 16'h8000) : {r8(), r8()};
			b = (r8() & 8'h3F) | 8'h01;
			s = r8();
			c = '0;
			c.rd = 5'h18;
			c.imm = b;
			wr(8'h18, w[7:0]);
			wr(8'h19, w[15:8]);
			wr(ADDR_STATUS, s);
			run(j[0] ? OP_WORD_SUB_IMM : OP_WORD_ADD_IMM);
			p = j[0] ? w - b : w + b;
			s[FLAG_C] = j[0] ? (b > w) : (p < w);
			s[FLAG_Z] = (p == 16'h0000);
			s[FLAG_N] = p[15];
			s[FLAG_V] = j[0] ? w[15] & ~p[15] : ~w[15] & p[15];
			s[FLAG_S] = s[FLAG_N] ^ s[FLAG_V];
			rd(8'h18, p[7:0], "word_lo");
			rd(8'h19, p[15:8], "word_hi");
			rd(ADDR_STATUS, s, "word_flags");
		end
		$display("word test done");
		for (int j = 0; j < 16; j++) begin
			s = r8();
			w = {r8(), r8()};
			wr(ADDR_STATUS, s);
			set_pc(w);
			c = '0;
			c.sel = j[2:0];
			x = r8();
			c.k = {x[3:0], r8()};
			run(j > 7 ? OP_BRANCH_FLAG_CLEAR : OP_BRANCH_FLAG_SET);
			x[0] = (j[2:0] == FLAG_S) ? s[FLAG_N] ^ s[FLAG_V] : s[j[2:0]];
			p = (x[0] ^ (j > 7)) ? w + {{4{c.k[11]}}, c.k} + 16'h1 : w + 16'h1;
			chk_pc(p);
		end
		$display("branch test done");
		for (int j = 0; j < 10; j++) begin
			a = r8();
			b = r8();
			x = r8();
			t2 = j > 4;
			if (x[7] || j % 5 != 0)
				b = a;
			w = {r8(), r8()};
			wr(8'h10, a);
			wr(8'h11, b);
			set_pc(w);
			c = '0;
			c.rd = 5'h10;
			c.rr = (j % 5 == 0) ? 5'h11 : 5'h10;
			c.sel = x[2:0];
			c.io_bit = t2;
			c.next_two_word = t2;
			run(sk_ops[j % 5]);
			case (j % 5)
			0: x[5] = (a == b);
			1: x[5] = !a[x[2:0]];
			2: x[5] = a[x[2:0]];
			3: x[5] = !t2;
			default: x[5] = t2;
			endcase
			p = x[5] ? (t2 ? 16'h3 : 16'h2) : 16'h1;
			chk_pc(w + p);
		end
		$display("skip test done");
		w = {r8(), r8()};
		p = {r8(), r8()};
		wr(8'h1E, p[7:0]);
		wr(8'h1F, p[15:8]);
		set_pc(w);
		wr(ADDR_STATUS, 8'h00);
		c = '0;
		c.target = p ^ 16'h5555;
		run(OP_IND_CALL);
		chk_pc(p);
		run(OP_INT_RETURN);
		chk_pc(w + 16'h1);
		rd(ADDR_STATUS, 8'h80, "status_after_return");
		run(OP_DIR_CALL);
		chk_pc(p ^ 16'h5555);
		run(OP_RETURN);
		chk_pc(w + 16'h3);
		run(OP_IND_JUMP);
		chk_pc(p);
		c.k = 12'h800;
		run(OP_REL_JUMP);
		chk_pc(p - 16'h07FF);
		run(OP_DIR_JUMP);
		chk_pc(c.target);
		run(OP_REL_CALL);
		chk_pc(c.target - 16'h07FF);
		run(OP_RETURN);
		chk_pc(c.target + 16'h0001);
		$display("jump test done");
		rst <= 1'b1;
		@(posedge clk_sys);
		rst <= 1'b0;
		chk_pc(PC_RESET);
		rd(8'h10, REG_RESET, "reg_after_reset");
		rd(ADDR_STATUS, STATUS_RESET, "status_after_reset");
		$display("second reset test done");
		repeat (2) @(posedge clk_sys);
		end_of_test();
	end
endmodule
`default_nettype wire

// ===== logic/cab_alu_branch.sv
/*
 * Arithmetic, logic, multiply, compare, skip and branch execution for an
 * 8-bit core, with its 32-entry register file, status flags, program
 * counter and return stack.
 * Assumes a decoder on clk_sys presenting one operation at a time and
 * holding it until busy is low; software reaches state over a plain
 * register port with read data one cycle after the read strobe.
 */
`default_nettype none

module cab_alu_branch (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	input wire cab_pkg::cab_bus_req_t bus_req,
	output logic [7:0] bus_rdata,
	input wire cab_pkg::cab_cmd_t cmd,
	output logic busy,
	output logic done,
	output logic [15:0] pc,
	output logic [7:0] status_flag_register
);
	import cab_pkg::*;

	logic [7:0] regs [32];
	logic [15:0] ret_stack [STACK_DEPTH];
	logic [2:0] sp;
	logic [2:0] wait_cnt;

	logic take;
	logic [7:0] rd_val;
	logic [7:0] rr_val;
	logic [7:0] opa;
	logic [7:0] opb;
	logic cin;
	logic [8:0] sum9;
	logic [4:0] sumh;
	logic [8:0] diff9;
	logic [4:0] diffh;
	logic [15:0] word_in;
	logic [16:0] wsum;
	logic [16:0] wdiff;
	logic [15:0] prod_uu;
	logic signed [15:0] prod_ss;
	logic signed [16:0] prod_su;
	logic [15:0] k_ext;
	logic [15:0] pc_rel;
	logic flag_bit;

	logic [7:0] next_flags;
	logic [7:0] next_res;
	logic next_wr8;
	logic next_wr16;
	logic [4:0] next_pair;
	logic [15:0] next_pair_data;
	logic [15:0] next_pc;
	logic [2:0] next_cycles;
	logic next_push;
	logic [15:0] next_push_val;
	logic next_pop;

	function automatic logic [7:0] add_flags(input logic [7:0] f,
			input logic [7:0] a, input logic [7:0] b, input logic [8:0] s,
			input logic h);
		logic [7:0] o;
		o = f;
		o[FLAG_C] = s[8];
		o[FLAG_Z] = (s[7:0] == 8'h00);
		o[FLAG_N] = s[7];
		o[FLAG_V] = (a[7] & b[7] & ~s[7]) | (~a[7] & ~b[7] & s[7]);
		o[FLAG_H] = h;
		return o;
	endfunction

	// Carry forms only keep Z set when it was already set before.
	function automatic logic [7:0] sub_flags(input logic [7:0] f,
			input logic [7:0] a, input logic [7:0] b, input logic [8:0] d,
			input logic h, input logic chain_z);
		logic [7:0] o;
		o = f;
		o[FLAG_C] = d[8];
		o[FLAG_Z] = (d[7:0] == 8'h00) & (~chain_z | f[FLAG_Z]);
		o[FLAG_N] = d[7];
		o[FLAG_V] = (a[7] & ~b[7] & ~d[7]) | (~a[7] & b[7] & d[7]);
		o[FLAG_H] = h;
		return o;
	endfunction

	function automatic logic [7:0] logic_flags(input logic [7:0] f,
			input logic [7:0] r);
		logic [7:0] o;
		o = f;
		o[FLAG_Z] = (r == 8'h00);
		o[FLAG_N] = r[7];
		o[FLAG_V] = 1'b0;
		return o;
	endfunction

	function automatic logic [7:0] mult_flags(input logic [7:0] f,
			input logic [15:0] p, input logic [15:0] r);
		logic [7:0] o;
		o = f;
		o[FLAG_C] = p[15];
		o[FLAG_Z] = (r == 16'h0000);
		return o;
	endfunction

	function automatic logic cin_form(input cab_op_t op);
		return op == OP_SUB_CARRY || op == OP_SUB_CARRY_IMM ||
			op == OP_COMPARE_CARRY;
	endfunction

	assign take = ce & cmd.valid & ~busy;
	assign rd_val = regs[cmd.rd];
	assign rr_val = regs[cmd.rr];
	assign word_in = {regs[{cmd.rd[4:1], 1'b1}], regs[{cmd.rd[4:1], 1'b0}]};

	// Operand selection shared by the adder and the subtractor.
	always_comb begin
		opa = rd_val;
		opb = rr_val;
		cin = 1'b0;
		unique case (cmd.op)
			OP_SUB_IMM, OP_COMPARE_IMM: opb = cmd.imm;
			OP_SUB_CARRY_IMM: begin
				opb = cmd.imm;
				cin = status_flag_register[FLAG_C];
			end
			OP_ADD_CARRY, OP_SUB_CARRY, OP_COMPARE_CARRY: begin
				cin = status_flag_register[FLAG_C];
			end
			OP_NEGATE: begin
				opa = 8'h00;
				opb = rd_val;
			end
			default: begin
				opa = rd_val;
				opb = rr_val;
			end
		endcase
	end

	assign sum9 = {1'b0, opa} + {1'b0, opb} + {8'h00, cin};
	assign sumh = {1'b0, opa[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
	assign diff9 = {1'b0, opa} - {1'b0, opb} - {8'h00, cin};
	assign diffh = {1'b0, opa[3:0]} - {1'b0, opb[3:0]} - {4'h0, cin};
	assign wsum = {1'b0, word_in} + {11'h000, cmd.imm[5:0]};
	assign wdiff = {1'b0, word_in} - {11'h000, cmd.imm[5:0]};
	assign prod_uu = {8'h00, rd_val} * {8'h00, rr_val};
	assign prod_ss = $signed(rd_val) * $signed(rr_val);
	assign prod_su = $signed({{9{rd_val[7]}}, rd_val}) *
		$signed({9'h000, rr_val});
	assign k_ext = {{4{cmd.k[11]}}, cmd.k};
	assign pc_rel = pc + k_ext + 16'h0001;

	// The signed test bit is formed from N and V directly.
	always_comb begin
		if (cmd.sel == 3'(FLAG_S)) begin
			flag_bit = status_flag_register[FLAG_N] ^
				status_flag_register[FLAG_V];
		end else begin
			flag_bit = status_flag_register[cmd.sel];
		end
	end

	always_comb begin
		logic skip;
		logic [15:0] p;
		logic [15:0] r;
		skip = 1'b0;
		p = 16'h0000;
		r = 16'h0000;
		next_flags = status_flag_register;
		next_res = 8'h00;
		next_wr8 = 1'b0;
		next_wr16 = 1'b0;
		next_pair = cmd.rd;
		next_pair_data = 16'h0000;
		next_pc = pc + 16'h0001;
		next_cycles = CYC_ALU;
		next_push = 1'b0;
		next_push_val = pc + 16'h0001;
		next_pop = 1'b0;
		unique case (cmd.op)
			OP_ADD, OP_ADD_CARRY: begin
				next_res = sum9[7:0];
				next_wr8 = 1'b1;
				next_flags = add_flags(status_flag_register, opa, opb, sum9,
					sumh[4]);
			end
			OP_SUB, OP_SUB_IMM, OP_SUB_CARRY, OP_SUB_CARRY_IMM: begin
				next_res = diff9[7:0];
				next_wr8 = 1'b1;
				next_flags = sub_flags(status_flag_register, opa, opb, diff9,
					diffh[4], cin_form(cmd.op));
			end
			OP_COMPARE, OP_COMPARE_CARRY, OP_COMPARE_IMM: begin
				next_flags = sub_flags(status_flag_register, opa, opb, diff9,
					diffh[4], cin_form(cmd.op));
			end
			OP_NEGATE: begin
				next_res = diff9[7:0];
				next_wr8 = 1'b1;
				next_flags = sub_flags(status_flag_register, opa, opb, diff9,
					diffh[4], 1'b0);
			end
			OP_WORD_ADD_IMM: begin
				next_wr16 = 1'b1;
				next_pair_data = wsum[15:0];
				next_cycles = CYC_WORD;
				next_flags[FLAG_C] = ~wsum[15] & word_in[15];
				next_flags[FLAG_V] = ~word_in[15] & wsum[15];
				next_flags[FLAG_N] = wsum[15];
				next_flags[FLAG_Z] = (wsum[15:0] == 16'h0000);
				next_flags[FLAG_S] = wsum[15] ^ (~word_in[15] & wsum[15]);
			end
			OP_WORD_SUB_IMM: begin
				next_wr16 = 1'b1;
				next_pair_data = wdiff[15:0];
				next_cycles = CYC_WORD;
				next_flags[FLAG_C] = wdiff[15] & ~word_in[15];
				next_flags[FLAG_V] = word_in[15] & ~wdiff[15];
				next_flags[FLAG_N] = wdiff[15];
				next_flags[FLAG_Z] = (wdiff[15:0] == 16'h0000);
				next_flags[FLAG_S] = wdiff[15] ^ (word_in[15] & ~wdiff[15]);
			end
			OP_AND, OP_AND_IMM, OP_OR, OP_OR_IMM, OP_XOR, OP_SET_BITS,
			OP_CLEAR_BITS, OP_TEST: begin
				unique case (cmd.op)
					OP_AND: next_res = rd_val & rr_val;
					OP_AND_IMM: next_res = rd_val & cmd.imm;
					OP_OR: next_res = rd_val | rr_val;
					OP_OR_IMM, OP_SET_BITS: next_res = rd_val | cmd.imm;
					OP_XOR: next_res = rd_val ^ rr_val;
					OP_CLEAR_BITS: next_res = rd_val & (ALL_ONES - cmd.imm);
					default: next_res = rd_val & rd_val;
				endcase
				next_wr8 = 1'b1;
				next_flags = logic_flags(status_flag_register, next_res);
			end
			OP_INVERT: begin
				next_res = ALL_ONES - rd_val;
				next_wr8 = 1'b1;
				next_flags = logic_flags(status_flag_register, next_res);
				next_flags[FLAG_C] = 1'b1;
			end
			OP_INCREMENT, OP_DECREMENT: begin
				next_res = (cmd.op == OP_INCREMENT) ? rd_val + 8'h01 :
					rd_val - 8'h01;
				next_wr8 = 1'b1;
				next_flags = logic_flags(status_flag_register, next_res);
				next_flags[FLAG_V] = (cmd.op == OP_INCREMENT) ?
					(next_res == 8'h80) : (next_res == 8'h7F);
			end
			OP_SET_ALL: begin
				next_res = ALL_ONES;
				next_wr8 = 1'b1;
			end
			OP_MULT_UU, OP_MULT_SS, OP_MULT_SU, OP_FRAC_MULT_UU,
			OP_FRAC_MULT_SS, OP_FRAC_MULT_SU: begin
				unique case (cmd.op)
					OP_MULT_UU, OP_FRAC_MULT_UU: p = prod_uu;
					OP_MULT_SS, OP_FRAC_MULT_SS: p = prod_ss;
					default: p = prod_su[15:0];
				endcase
				if (cmd.op == OP_FRAC_MULT_UU || cmd.op == OP_FRAC_MULT_SS ||
						cmd.op == OP_FRAC_MULT_SU) begin
					r = {p[14:0], 1'b0};
				end else begin
					r = p;
				end
				next_wr16 = 1'b1;
				next_pair = PRODUCT_PAIR;
				next_pair_data = r;
				next_cycles = CYC_MUL;
				next_flags = mult_flags(status_flag_register, p, r);
			end
			OP_REL_JUMP: begin
				next_pc = pc_rel;
				next_cycles = CYC_REL_JUMP;
			end
			OP_IND_JUMP: begin
				next_pc = {regs[Z_PTR_LO + 5'h01], regs[Z_PTR_LO]};
				next_cycles = CYC_IND_JUMP;
			end
			OP_DIR_JUMP: begin
				next_pc = cmd.target;
				next_cycles = CYC_DIR_JUMP;
			end
			OP_REL_CALL: begin
				next_pc = pc_rel;
				next_push = 1'b1;
				next_cycles = CYC_REL_CALL;
			end
			OP_IND_CALL: begin
				next_pc = {regs[Z_PTR_LO + 5'h01], regs[Z_PTR_LO]};
				next_push = 1'b1;
				next_cycles = CYC_IND_CALL;
			end
			OP_DIR_CALL: begin
				next_pc = cmd.target;
				next_push = 1'b1;
				next_push_val = pc + 16'h0002;
				next_cycles = CYC_DIR_CALL;
			end
			OP_RETURN, OP_INT_RETURN: begin
				next_pc = ret_stack[sp - 3'h1];
				next_pop = 1'b1;
				next_cycles = CYC_RETURN;
				if (cmd.op == OP_INT_RETURN) begin
					next_flags[FLAG_I] = 1'b1;
				end
			end
			OP_COMPARE_SKIP_EQUAL, OP_SKIP_REG_BIT_CLEAR, OP_SKIP_REG_BIT_SET,
			OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET: begin
				unique case (cmd.op)
					OP_COMPARE_SKIP_EQUAL: skip = (rd_val == rr_val);
					OP_SKIP_REG_BIT_CLEAR: skip = ~rr_val[cmd.sel];
					OP_SKIP_REG_BIT_SET: skip = rr_val[cmd.sel];
					OP_SKIP_IO_BIT_CLEAR: skip = ~cmd.io_bit;
					default: skip = cmd.io_bit;
				endcase
				if (skip && cmd.next_two_word) begin
					next_pc = pc + 16'h0003;
					next_cycles = CYC_SKIP_TWO_WORD;
				end else if (skip) begin
					next_pc = pc + 16'h0002;
					next_cycles = CYC_SKIP_ONE_WORD;
				end
			end
			OP_BRANCH_FLAG_SET, OP_BRANCH_FLAG_CLEAR: begin
				if (flag_bit == (cmd.op == OP_BRANCH_FLAG_SET)) begin
					next_pc = pc_rel;
					next_cycles = CYC_BRANCH_TAKEN;
				end
			end
		endcase
	end

	// Instruction writes follow bus writes so they win on a collision.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			for (int i = 0; i < 32; i++) begin
				regs[i] <= REG_RESET;
			end
		end else if (ce) begin
			if (bus_req.wr && bus_req.addr <= ADDR_REGFILE_LAST) begin
				regs[bus_req.addr[4:0]] <= bus_req.wdata;
			end
			if (take && next_wr8) begin
				regs[cmd.rd] <= next_res;
			end
			if (take && next_wr16) begin
				regs[{next_pair[4:1], 1'b0}] <= next_pair_data[7:0];
				regs[{next_pair[4:1], 1'b1}] <= next_pair_data[15:8];
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			status_flag_register <= STATUS_RESET;
		end else if (ce) begin
			if (take) begin
				status_flag_register <= next_flags;
			end else if (bus_req.wr && bus_req.addr == ADDR_STATUS) begin
				status_flag_register <= bus_req.wdata;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pc <= PC_RESET;
		end else if (ce) begin
			if (take) begin
				pc <= next_pc;
			end else if (bus_req.wr && bus_req.addr == ADDR_PC_LO) begin
				pc[7:0] <= bus_req.wdata;
			end else if (bus_req.wr && bus_req.addr == ADDR_PC_HI) begin
				pc[15:8] <= bus_req.wdata;
			end
		end
	end

	// Return stack wraps silently when over- or under-run.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sp <= 3'h0;
			for (int i = 0; i < STACK_DEPTH; i++) begin
				ret_stack[i] <= PC_RESET;
			end
		end else if (ce && take) begin
			if (next_push) begin
				ret_stack[sp] <= next_push_val;
				sp <= sp + 3'h1;
			end else if (next_pop) begin
				sp <= sp - 3'h1;
			end
		end
	end

	// The operation takes effect at acceptance; busy covers the rest.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			busy <= 1'b0;
			done <= 1'b0;
			wait_cnt <= 3'h0;
		end else if (ce) begin
			if (take) begin
				wait_cnt <= next_cycles - 3'h1;
				busy <= (next_cycles != CYC_ALU);
				done <= (next_cycles == CYC_ALU);
			end else if (busy) begin
				wait_cnt <= wait_cnt - 3'h1;
				busy <= (wait_cnt != 3'h1);
				done <= (wait_cnt == 3'h1);
			end else begin
				done <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			bus_rdata <= 8'h00;
		end else if (ce) begin
			if (!bus_req.rd) begin
				bus_rdata <= 8'h00;
			end else if (bus_req.addr <= ADDR_REGFILE_LAST) begin
				bus_rdata <= regs[bus_req.addr[4:0]];
			end else if (bus_req.addr == ADDR_STATUS) begin
				bus_rdata <= status_flag_register;
			end else if (bus_req.addr == ADDR_PC_LO) begin
				bus_rdata <= pc[7:0];
			end else if (bus_req.addr == ADDR_PC_HI) begin
				bus_rdata <= pc[15:8];
			end else if (bus_req.addr == ADDR_STACK_PTR) begin
				bus_rdata <= {5'h00, sp};
			end else begin
				bus_rdata <= 8'h00;
			end
		end
	end

endmodule

`default_nettype wire

// ===== logic/cab_pkg.sv
/*
 * Shared constants and types for the ALU and branch unit: register map of
 * the plain register port, status flag positions, cycle counts, the
 * operation set and the request carriers.
 * Assumes a single 25 MHz clock and a decoder on that clock that issues
 * one already-decoded operation at a time.
 */
`default_nettype none

package cab_pkg;

	// Status flag bit positions.
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_S = 4;
	localparam int FLAG_H = 5;
	localparam int FLAG_T = 6;
	localparam int FLAG_I = 7;

	// Register port map.
	localparam logic [7:0] ADDR_REGFILE_LAST = 8'h1F;
	localparam logic [7:0] ADDR_STATUS = 8'h20;
	localparam logic [7:0] ADDR_PC_LO = 8'h21;
	localparam logic [7:0] ADDR_PC_HI = 8'h22;
	localparam logic [7:0] ADDR_STACK_PTR = 8'h23;

	// Reset values.
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [15:0] PC_RESET = 16'h0000;
	localparam logic [7:0] REG_RESET = 8'h00;

	// Fixed register indices and constants.
	localparam logic [4:0] Z_PTR_LO = 5'h1E;
	localparam logic [4:0] PRODUCT_PAIR = 5'h00;
	localparam logic [7:0] ALL_ONES = 8'hFF;
	localparam int STACK_DEPTH = 8;

	// Cycle counts per operation class.
	localparam logic [2:0] CYC_ALU = 3'h1;
	localparam logic [2:0] CYC_WORD = 3'h2;
	localparam logic [2:0] CYC_MUL = 3'h2;
	localparam logic [2:0] CYC_REL_JUMP = 3'h2;
	localparam logic [2:0] CYC_IND_JUMP = 3'h2;
	localparam logic [2:0] CYC_DIR_JUMP = 3'h3;
	localparam logic [2:0] CYC_REL_CALL = 3'h3;
	localparam logic [2:0] CYC_IND_CALL = 3'h3;
	localparam logic [2:0] CYC_DIR_CALL = 3'h4;
	localparam logic [2:0] CYC_RETURN = 3'h4;
	localparam logic [2:0] CYC_BRANCH_TAKEN = 3'h2;
	localparam logic [2:0] CYC_SKIP_ONE_WORD = 3'h2;
	localparam logic [2:0] CYC_SKIP_TWO_WORD = 3'h3;

	typedef enum logic [5:0] {
		OP_ADD, OP_ADD_CARRY, OP_WORD_ADD_IMM,
		OP_SUB, OP_SUB_IMM, OP_SUB_CARRY, OP_SUB_CARRY_IMM, OP_WORD_SUB_IMM,
		OP_AND, OP_AND_IMM, OP_OR, OP_OR_IMM, OP_XOR,
		OP_SET_BITS, OP_CLEAR_BITS, OP_TEST, OP_INVERT, OP_NEGATE,
		OP_INCREMENT, OP_DECREMENT, OP_SET_ALL,
		OP_MULT_UU, OP_MULT_SS, OP_MULT_SU,
		OP_FRAC_MULT_UU, OP_FRAC_MULT_SS, OP_FRAC_MULT_SU,
		OP_REL_JUMP, OP_IND_JUMP, OP_DIR_JUMP,
		OP_REL_CALL, OP_IND_CALL, OP_DIR_CALL,
		OP_RETURN, OP_INT_RETURN,
		OP_COMPARE_SKIP_EQUAL, OP_COMPARE, OP_COMPARE_CARRY, OP_COMPARE_IMM,
		OP_SKIP_REG_BIT_CLEAR, OP_SKIP_REG_BIT_SET,
		OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET,
		OP_BRANCH_FLAG_SET, OP_BRANCH_FLAG_CLEAR
	} cab_op_t;

	typedef struct packed {
		logic valid;
		cab_op_t op;
		logic [4:0] rd;
		logic [4:0] rr;
		logic [7:0] imm;
		logic [2:0] sel;
		logic [11:0] k;
		logic [15:0] target;
		logic io_bit;
		logic next_two_word;
	} cab_cmd_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} cab_bus_req_t;

endpackage

`default_nettype wire
